// ===== hw/xcvr_pkg.sv
package xcvr_pkg;

  // ----------------------------------------------------------------
  // lane count and clock
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam int CLK_PERIOD_NS = 25;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] LOAD_COUNT_OFFSET = 4'h8;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int CTRL_SW_LOAD_BIT = 1;
  localparam logic CTRL_INHIBIT_RESET = 1'b0;

  // ----------------------------------------------------------------
  // status register fields (one byte per lane group)
  // ----------------------------------------------------------------
  localparam int STAT_TX_POS = 0;
  localparam int STAT_RX_POS = 8;
  localparam int STAT_LINE_POS = 16;
  localparam int STAT_PARITY_BIT = 24;
  localparam int STAT_DRIVE_GATE_BIT = 25;
  localparam int STAT_HOLD_GATE_BIT = 26;
  localparam int STAT_RX_GATE_BIT = 27;
  localparam int STAT_PICK_BIT = 28;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TX_RESET = 8'h00;
  localparam logic [7:0] RX_RESET = 8'h00;
  localparam logic [7:0] LOAD_COUNT_RESET = 8'h00;
  localparam logic PARITY_RESET = 1'b1;

  // ----------------------------------------------------------------
  // bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage : xcvr_pkg

// ===== hw/odd_parity.sv
`timescale 1ns/100ps
module odd_parity #(
  parameter int WIDTH = 4
) (
  input wire logic [WIDTH-1:0] data,
  output logic parity
);

  // ----------------------------------------------------------------
  // width check
  // ----------------------------------------------------------------
  initial begin
    if (WIDTH < 1) begin
      $error("odd_parity width must be at least one");
    end
  end

  // ----------------------------------------------------------------
  // ripple of exclusive-or terms
  // ----------------------------------------------------------------
  logic [WIDTH:0] chain;

  assign chain[0] = 1'b0;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_chain
      assign chain[i+1] = chain[i] ^ data[i];
    end
  endgenerate

  // high when the data hold an even count of ones
  assign parity = ~chain[WIDTH];

endmodule : odd_parity

// ===== hw/quad_bus_transceiver_parity.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
module quad_bus_transceiver_parity
  import xcvr_pkg::*;
#(
  parameter int WIDTH = LANES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] word_one_in,
  input wire logic [WIDTH-1:0] word_two_in,
  input wire logic word_pick,
  input wire logic tx_reg_clock,
  input wire logic line_drive_gate,
  input wire logic receive_hold_gate,
  input wire logic rx_out_gate,
  input wire logic [WIDTH-1:0] shared_line_in,
  output logic [WIDTH-1:0] shared_line_out,
  output logic [WIDTH-1:0] shared_line_oe,
  output logic [WIDTH-1:0] rx_out,
  output logic [WIDTH-1:0] rx_out_oe,
  output logic parity_out,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // each lane group owns one status byte, so eight lanes at most
  initial begin
    if (WIDTH < 1 || WIDTH > 8) begin
      $error("transceiver width must lie between one and eight");
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] tx_reg_bit_reg;
  logic [WIDTH-1:0] tx_reg_bit_next;
  logic [WIDTH-1:0] rx_latch_state_reg;
  logic [WIDTH-1:0] picked_word;
  logic tx_clock_prev_reg;
  logic tx_clock_rise;
  logic inhibit_reg;
  logic sw_load;
  logic tx_load;
  logic release_drivers;
  logic gen_parity;
  logic chk_parity;
  logic parity_reg;
  logic [7:0] load_count_reg;
  logic [7:0] load_count_next;
  logic count_clear;
  bus_state_t bus_state_reg;
  logic [31:0] readdata_reg;
  logic [31:0] read_word;
  logic [31:0] status_word;
  logic bus_req;
  logic bus_done;
  logic wr_ctrl;
  logic wr_count;

  // ----------------------------------------------------------------
  // driver input multiplexer
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pick
      assign picked_word[i] = word_pick ? word_two_in[i]
                                        : word_one_in[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // driver clock edge
  // ----------------------------------------------------------------
  // the pin is sampled on core_clk; a pulse shorter than one period
  // can be missed, which limits the usable driver clock rate
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_clock_prev_reg <= 1'b0;
    end else begin
      tx_clock_prev_reg <= tx_reg_clock;
    end
  end

  assign tx_clock_rise = tx_reg_clock & ~tx_clock_prev_reg;

  // a software load stands in for one rising edge of the pin clock
  assign tx_load = tx_clock_rise | sw_load;

  // ----------------------------------------------------------------
  // driver register
  // ----------------------------------------------------------------
  always_comb begin
    tx_reg_bit_next = tx_reg_bit_reg;
    if (tx_load) begin
      tx_reg_bit_next = picked_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_reg_bit_reg <= TX_RESET[WIDTH-1:0];
    end else begin
      tx_reg_bit_reg <= tx_reg_bit_next;
    end
  end

  // ----------------------------------------------------------------
  // open-collector bus drivers
  // ----------------------------------------------------------------
  // a driver can only pull low; a one in the register pulls its line
  // low and a zero releases it, so other drivers may share the wire
  assign release_drivers = line_drive_gate | inhibit_reg;

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_drive
      assign shared_line_out[i] = 1'b0;
      assign shared_line_oe[i] = ~release_drivers
                                 & tx_reg_bit_reg[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // receiver latches
  // ----------------------------------------------------------------
  // transparency costs one core_clk of delay from line to output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_latch_state_reg <= RX_RESET[WIDTH-1:0];
    end else if (!receive_hold_gate) begin
      rx_latch_state_reg <= ~shared_line_in;
    end
  end
  // when the hold gate is high only reset above writes the latches

  // ----------------------------------------------------------------
  // receiver outputs
  // ----------------------------------------------------------------
  // the output gate only steers the enables; latch contents stay
  assign rx_out = rx_latch_state_reg;
  assign rx_out_oe = {WIDTH{~rx_out_gate}};

  // ----------------------------------------------------------------
  // parity generator and checker
  // ----------------------------------------------------------------
  odd_parity #(
    .WIDTH(WIDTH)
  ) u_gen_parity (
    .data(picked_word),
    .parity(gen_parity)
  );

  odd_parity #(
    .WIDTH(WIDTH)
  ) u_chk_parity (
    .data(rx_latch_state_reg),
    .parity(chk_parity)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      parity_reg <= PARITY_RESET;
    end else if (release_drivers) begin
      parity_reg <= chk_parity;
    end else begin
      parity_reg <= gen_parity;
    end
  end

  assign parity_out = parity_reg;

  // ----------------------------------------------------------------
  // driver load counter
  // ----------------------------------------------------------------
  // a load in the cycle of a software clear still counts
  always_comb begin
    load_count_next = load_count_reg;
    if (count_clear) begin
      load_count_next = LOAD_COUNT_RESET;
    end
    if (tx_load) begin
      if (count_clear) begin
        load_count_next = 8'h01;
      end else begin
        load_count_next = load_count_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      load_count_reg <= LOAD_COUNT_RESET;
    end else begin
      load_count_reg <= load_count_next;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: request, answer one cycle later
  // ----------------------------------------------------------------
  assign bus_req = read | write;
  assign bus_done = bus_req & (bus_state_reg == BUS_ANSWER);
  assign waitrequest = bus_req & (bus_state_reg != BUS_ANSWER);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_state_reg <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          bus_state_reg <= BUS_IDLE;
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  assign wr_ctrl = write & bus_done & byteenable[0]
                   & (address == CTRL_OFFSET);
  assign wr_count = write & bus_done & byteenable[0]
                    & (address == LOAD_COUNT_OFFSET);
  assign sw_load = wr_ctrl & writedata[CTRL_SW_LOAD_BIT];
  assign count_clear = wr_count;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      inhibit_reg <= CTRL_INHIBIT_RESET;
    end else if (wr_ctrl) begin
      inhibit_reg <= writedata[CTRL_INHIBIT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_TX_POS +: WIDTH] = tx_reg_bit_reg;
    status_word[STAT_RX_POS +: WIDTH] = rx_latch_state_reg;
    status_word[STAT_LINE_POS +: WIDTH] = shared_line_in;
    status_word[STAT_PARITY_BIT] = parity_reg;
    status_word[STAT_DRIVE_GATE_BIT] = line_drive_gate;
    status_word[STAT_HOLD_GATE_BIT] = receive_hold_gate;
    status_word[STAT_RX_GATE_BIT] = rx_out_gate;
    status_word[STAT_PICK_BIT] = word_pick;
  end

  always_comb begin
    read_word = 32'h0000_0000;
    case (address)
      CTRL_OFFSET: begin
        read_word[CTRL_INHIBIT_BIT] = inhibit_reg;
      end
      STATUS_OFFSET: begin
        read_word = status_word;
      end
      LOAD_COUNT_OFFSET: begin
        read_word[7:0] = load_count_reg;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // captured in the first cycle of a read, shown while waitrequest
  // is low in the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read && bus_state_reg == BUS_IDLE) begin
      readdata_reg <= read_word;
    end
  end

  assign readdata = readdata_reg;

endmodule : quad_bus_transceiver_parity

// ===== test/shared_line_model.sv
`timescale 1ns/100ps
module shared_line_model (
  input wire logic [3:0] pull_oe,
  input wire logic [3:0] pull_out,
  input wire logic [3:0] other_pull,
  output logic [3:0] line
);
  // ----
  // wired-or bus with pull-up
  // ----
  // an unpulled line returns to the pull-up, never holds its last value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line[i] = ((pull_oe[i] && !pull_out[i]) || other_pull[i]) ? 1'b0
        : 1'b1;
    end
  end
endmodule : shared_line_model

// ===== test/xcvr_asserts.sv
`timescale 1ns/100ps
module xcvr_asserts
  import xcvr_pkg::*;
#(
  parameter int WIDTH = LANES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] word_one_in,
  input wire logic [WIDTH-1:0] word_two_in,
  input wire logic word_pick,
  input wire logic tx_reg_clock,
  input wire logic line_drive_gate,
  input wire logic receive_hold_gate,
  input wire logic rx_out_gate,
  input wire logic [WIDTH-1:0] shared_line_in,
  input wire logic [WIDTH-1:0] shared_line_out,
  input wire logic [WIDTH-1:0] shared_line_oe,
  input wire logic [WIDTH-1:0] rx_out,
  input wire logic [WIDTH-1:0] rx_out_oe,
  input wire logic parity_out,
  input wire logic [3:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest
);
  // ----
  // helper state
  // ----
  logic inh;
  logic wr_ctl;
  logic sw_ld;
  logic drv;
  logic [WIDTH-1:0] pick_q;
  assign wr_ctl = write && !waitrequest && address == CTRL_OFFSET
    && byteenable[0];
  assign sw_ld = wr_ctl && writedata[CTRL_SW_LOAD_BIT];
  assign drv = !line_drive_gate && !inh;
  // inhibit is not a port, so it is tracked from completed writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inh <= CTRL_INHIBIT_RESET;
    end else if (wr_ctl) begin
      inh <= writedata[CTRL_INHIBIT_BIT];
    end
  end
  always_ff @(posedge core_clk) begin
    pick_q <= word_pick ? word_two_in : word_one_in;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_load;
    ($rose(tx_reg_clock) && drv) ##1 drv;
  endsequence
  sequence s_keep;
    (drv && !$rose(tx_reg_clock) && !sw_ld) ##1 drv;
  endsequence
  // ----
  // properties
  // ----
  load_pick_a: assert property (s_load |-> shared_line_oe == pick_q
    && shared_line_out == '0) else $error("bad driver load");
  tx_hold_a: assert property (s_keep |-> $stable(shared_line_oe))
    else $error("driver register changed");
  drive_float_a: assert property (line_drive_gate |->
    shared_line_oe == '0) else $error("drivers not floated");
  rx_follow_a: assert property (!receive_hold_gate |=>
    rx_out == ~$past(shared_line_in)) else $error("receiver not following");
  hold_keep_a: assert property (receive_hold_gate |=> $stable(rx_out))
    else $error("latch changed while held");
  rx_float_a: assert property (rx_out_oe == {WIDTH{!rx_out_gate}})
    else $error("receiver enable wrong");
  par_gen_a: assert property (drv |=> parity_out == ~(^pick_q))
    else $error("generated parity wrong");
  par_chk_a: assert property ((line_drive_gate || inh) |=>
    parity_out == ~(^$past(rx_out))) else $error("checked parity wrong");
endmodule : xcvr_asserts

bind quad_bus_transceiver_parity xcvr_asserts #(.WIDTH(WIDTH)) xcvr_asserts_i (
  .core_clk, .rst, .word_one_in, .word_two_in, .word_pick, .tx_reg_clock,
  .line_drive_gate, .receive_hold_gate, .rx_out_gate, .shared_line_in,
  .shared_line_out, .shared_line_oe, .rx_out, .rx_out_oe, .parity_out,
  .address, .write, .writedata, .byteenable, .waitrequest);

// ===== test/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import xcvr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] word_one_in = 4'h0, word_two_in = 4'h0, other_pull = 4'h0;
  logic word_pick = 1'b0, tx_reg_clock = 1'b0, line_drive_gate = 1'b0;
  logic receive_hold_gate = 1'b0, rx_out_gate = 1'b0;
  logic read = 1'b0, write = 1'b0;
  logic [3:0] address = 4'h0, byteenable = 4'hf;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0] line, line_out, line_oe, rx_out, rx_out_oe;
  logic parity_out, waitrequest;
  int failures = 0, n_checks = 0;
  always #12.5 core_clk = ~core_clk;
  shared_line_model shared_line_model_i (.pull_oe(line_oe),
    .pull_out(line_out), .other_pull(other_pull), .line(line));
  quad_bus_transceiver_parity quad_bus_transceiver_parity_i (
    .core_clk(core_clk), .rst(rst), .word_one_in(word_one_in),
    .word_two_in(word_two_in), .word_pick(word_pick),
    .tx_reg_clock(tx_reg_clock), .line_drive_gate(line_drive_gate),
    .receive_hold_gate(receive_hold_gate), .rx_out_gate(rx_out_gate),
    .shared_line_in(line), .shared_line_out(line_out),
    .shared_line_oe(line_oe), .rx_out(rx_out), .rx_out_oe(rx_out_oe),
    .parity_out(parity_out), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest));
  // ----
  // tasks
  // ----
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // a completed request always lies on a rising edge, so no half cycles
  task automatic bus(input logic wr, input logic [3:0] adr,
                     input logic [31:0] wd, output logic [31:0] rdat);
    int i;
    @(posedge core_clk);
    read <= !wr;
    write <= wr;
    address <= adr;
    writedata <= wd;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (!waitrequest) break;
    end
    rdat = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      failures++;
      summarize();
    end
  endtask : bus
  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask : settle
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    summarize();
  end
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] d;
    logic [3:0] exp;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      exp = (p == 1) ? 4'hb : 4'h6;
      @(posedge core_clk);
      word_pick <= (p == 1);
      word_one_in <= 4'h6;
      word_two_in <= 4'hb;
      tx_reg_clock <= 1'b1;
      settle();
      check(line_oe, exp);
      check(line, 4'(~exp));
      check(parity_out, ~^exp);
      @(posedge core_clk);
      tx_reg_clock <= 1'b0;
      word_one_in <= 4'h7;
      word_two_in <= 4'h3;
      settle();
      check(line_oe, exp);
      check(parity_out, (p == 1) ? 1'b1 : 1'b0);
    end
    $display("driver load test done");
    @(posedge core_clk);
    line_drive_gate <= 1'b1;
    other_pull <= 4'h5;
    settle();
    check(line_oe, 4'h0);
    check(rx_out, 4'h5);
    check(parity_out, 1'b1);
    @(posedge core_clk);
    receive_hold_gate <= 1'b1;
    other_pull <= 4'h7;
    settle();
    check(rx_out, 4'h5);
    @(posedge core_clk);
    rx_out_gate <= 1'b1;
    settle();
    check(rx_out_oe, 4'h0);
    @(posedge core_clk);
    rx_out_gate <= 1'b0;
    receive_hold_gate <= 1'b0;
    settle();
    check(rx_out_oe, 4'hf);
    check(rx_out, 4'h7);
    check(parity_out, 1'b0);
    @(posedge core_clk);
    line_drive_gate <= 1'b0;
    settle();
    check(line, 4'h0);
    check(rx_out, 4'hf);
    $display("receive test done");
    bus(1'b0, STATUS_OFFSET, 32'h0, d);
    check(d[3:0], 4'hb);
    check(d[19:8], 12'h00f);
    check(d[28:24], 5'h11);
    bus(1'b0, 4'hc, 32'h0, d);
    check(d, 32'h0);
    bus(1'b1, CTRL_OFFSET, 32'h1, d);
    settle();
    check(line_oe, 4'h0);
    bus(1'b1, CTRL_OFFSET, 32'h0, d);
    settle();
    check(line_oe, 4'hb);
    bus(1'b0, LOAD_COUNT_OFFSET, 32'h0, d);
    check(d, 32'h2);
    @(posedge core_clk);
    byteenable <= 4'he;
    bus(1'b1, CTRL_OFFSET, 32'h1, d);
    settle();
    check(line_oe, 4'hb);
    @(posedge core_clk);
    byteenable <= 4'hf;
    bus(1'b1, CTRL_OFFSET, 32'h2, d);
    settle();
    check(line_oe, 4'h3);
    bus(1'b0, CTRL_OFFSET, 32'h0, d);
    check(d, 32'h0);
    bus(1'b0, LOAD_COUNT_OFFSET, 32'h0, d);
    check(d, 32'h3);
    bus(1'b1, LOAD_COUNT_OFFSET, 32'h0, d);
    bus(1'b0, LOAD_COUNT_OFFSET, 32'h0, d);
    check(d, 32'h0);
    $display("register test done");
    summarize();
  end
endmodule : tb_top
